//--- eet_defs.svh
// shared offsets, timing figures and sizes for the two-wire eeprom target
`ifndef EET_DEFS_SVH
`define EET_DEFS_SVH
`define EET_CLK_NS 50
`define EET_FILT_NS 100
`define EET_PU_MS 1
`define EET_TWR_MS 5
`define EET_NS_PER_MS 1000000
`define EET_PAGE_BYTES 32
`define EET_ADDR_BITS 13
`define EET_BITS_PER_BYTE 8
`define EET_SYNC_SCL 0
`define EET_SYNC_SDA 1
`define EET_SYNC_WI 2
`define EET_SYNC_STRAP 3
`endif

//--- eet_pkg.sv
// types shared by the two-wire eeprom target
`default_nettype none
package eet_pkg;
  // bus-side sequencer, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_RX_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_TX_ACK = 5'h10
  } eet_state_type;
  // which byte of the command is being received
  typedef enum logic [1:0] {
    PH_DEV = 2'h0,
    PH_HI = 2'h1,
    PH_LO = 2'h2,
    PH_DATA = 2'h3
  } eet_phase_type;
endpackage : eet_pkg
`default_nettype wire

//--- eet_target.sv
// two-wire bus target front end with page buffer and memory array
// Function
// - device is target only; controller clocks bus
// - start is sda fall, scl high
// - stop is sda rise, scl high; ends command
// - sample on scl rise, drive after fall
// - sda only pulled low or released
// - address byte matches type code and straps
// - last address bit: 1 read, 0 write
// - ninth clock is the acknowledge slot
// - inhibit pin high refuses all writes
// - pinless variant: straps 000, writes allowed
// - ready for commands within 1 ms
// - reset returns to reset, release to standby
// - pulses up to 100 ns are filtered
// - page write wraps, stop commits buffer
// - no address acknowledge during internal write
// - inhibit strobed before first data byte
// - sequential read increments, wraps whole memory
`default_nettype none
`include "eet_defs.svh"
module eet_target
  import eet_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = 4'h5, // arbitrary device-type code
  parameter bit HAS_PINS = 1'b1,
  parameter int PU_CYCLES = `EET_PU_MS * `EET_NS_PER_MS / `EET_CLK_NS,
  parameter int TWR_CYCLES = `EET_TWR_MS * `EET_NS_PER_MS / `EET_CLK_NS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_bit_zero,
  input wire logic strap_bit_one,
  input wire logic strap_bit_two,
  input wire logic write_inhibit,
  output logic device_ready,
  output logic write_busy
);
  // ==========================================================
  // constants
  localparam int FILT_CYC = `EET_FILT_NS / `EET_CLK_NS; // longest pulse, rounded down
  localparam int DEPTH = 1 << `EET_ADDR_BITS;
  localparam int PW = $clog2(`EET_PAGE_BYTES);
  localparam int PUW = $clog2(PU_CYCLES + 1);
  localparam int TWW = $clog2(TWR_CYCLES + 1);

  // ==========================================================
  // pin synchronisers and glitch filter
  logic [5:0] sync1_q; // first stage, read only by second
  logic [5:0] sync2_q; // resynchronised pins
  logic [1:0] flt_q; // filtered scl (0) and sda (1)
  logic [1:0] flt_prev_q; // filtered values one cycle back

  // every pin passes two flops before anything looks at it
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sync1_q <= 6'h03;
      sync2_q <= 6'h03;
    end else begin
      sync1_q <= {strap_bit_two, strap_bit_one, strap_bit_zero, write_inhibit, sda_in, scl_in};
      sync2_q <= sync1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      logic [1:0] cnt_q; // cycles the line has differed
      // a new level is taken only after FILT_CYC+1 steady samples
      always_ff @(posedge clock) begin
        if (!resetn) begin
          cnt_q <= 2'h0;
          flt_q[g] <= 1'b1;
          flt_prev_q[g] <= 1'b1;
        end else begin
          flt_prev_q[g] <= flt_q[g];
          if (sync2_q[g] == flt_q[g]) begin
            cnt_q <= 2'h0;
          end else if (cnt_q == 2'(FILT_CYC)) begin
            flt_q[g] <= sync2_q[g];
            cnt_q <= 2'h0;
          end else begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // bus events
  logic scl_rise, scl_fall, start_det, stop_det;
  logic sda_now;
  logic [2:0] strap_eff;
  logic inhibit_eff;
  assign sda_now = flt_q[1];
  assign scl_rise = flt_q[0] & ~flt_prev_q[0];
  assign scl_fall = ~flt_q[0] & flt_prev_q[0];
  // sda edges while scl stays high mark start and stop
  assign start_det = flt_q[0] & flt_prev_q[0] & flt_prev_q[1] & ~flt_q[1];
  assign stop_det = flt_q[0] & flt_prev_q[0] & ~flt_prev_q[1] & flt_q[1];
  // the pinless variant behaves as if straps are low and writes free
  assign strap_eff = HAS_PINS ? sync2_q[`EET_SYNC_STRAP +: 3] : 3'h0;
  assign inhibit_eff = HAS_PINS ? sync2_q[`EET_SYNC_WI] : 1'b0;

  // ==========================================================
  // power-up: standby only after the ready delay
  logic [PUW-1:0] pu_cnt_q; // cycles since reset release
  logic ready_q; // accepting commands

  // synchronous reset stands for the power-on detector; re-asserting it
  // at any time drops back to reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pu_cnt_q <= '0;
      ready_q <= 1'b0;
    end else if (!ready_q) begin
      if (pu_cnt_q == PUW'(PU_CYCLES - 1)) begin
        ready_q <= 1'b1;
      end
      pu_cnt_q <= pu_cnt_q + PUW'(1);
    end
  end

  // ==========================================================
  // bus sequencer
  eet_state_type state_q; // bit-level state
  eet_phase_type phase_q; // byte within command
  logic [3:0] bit_q; // rising edges seen in this byte
  logic [7:0] shift_q; // byte in or out
  logic rw_q; // direction of current command
  logic ack_q; // acknowledge of current slot
  logic wp_q; // inhibit strobed before first data byte
  logic wr_any_q; // page buffer holds new bytes
  logic oe_q; // pull sda low
  logic [`EET_ADDR_BITS-1:0] addr_q; // current byte address
  logic [7:0] page_buf [`EET_PAGE_BYTES]; // page write buffer
  logic [`EET_PAGE_BYTES-1:0] valid_q; // buffer entries loaded
  logic [7:0] mem [DEPTH]; // memory array
  logic busy_q; // internal write in progress
  logic ack_ok;
  logic commit_go;

  // decide the acknowledge for the byte just received
  always_comb begin
    case (phase_q)
      PH_DEV: ack_ok = shift_q[7:4] == DEV_TYPE && shift_q[3:1] == strap_eff && !busy_q;
      PH_DATA: ack_ok = !wp_q;
      default: ack_ok = 1'b1;
    endcase
  end
  // a stop after accepted data bytes starts the internal write
  assign commit_go = stop_det && ready_q && phase_q == PH_DATA && !rw_q && wr_any_q;

  // bit and byte sequencing; the controller owns scl, we only follow
  always_ff @(posedge clock) begin
    if (!resetn || !ready_q) begin
      state_q <= ST_IDLE;
      phase_q <= PH_DEV;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      wp_q <= 1'b0;
      wr_any_q <= 1'b0;
      oe_q <= 1'b0;
      addr_q <= '0;
      valid_q <= '0;
    end else if (start_det) begin
      // also a repeated start: decode the address afresh
      state_q <= ST_RX;
      phase_q <= PH_DEV;
      bit_q <= 4'h0;
      oe_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      oe_q <= 1'b0;
      if (commit_go) begin
        wr_any_q <= 1'b0;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          oe_q <= 1'b0; // silent until a start
        end
        ST_RX: begin
          if (scl_rise && bit_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda_now};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            state_q <= ST_RX_ACK; // ninth clock
            ack_q <= ack_ok;
            oe_q <= ack_ok;
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            oe_q <= 1'b0;
            bit_q <= 4'h0;
            state_q <= ST_RX;
            if (!ack_q) begin
              state_q <= ST_IDLE; // refused: wait for the next start
            end else begin
              case (phase_q)
                PH_DEV: begin
                  rw_q <= shift_q[0];
                  if (shift_q[0]) begin
                    state_q <= ST_TX;
                    shift_q <= mem[addr_q];
                    oe_q <= ~mem[addr_q][7];
                    addr_q <= addr_q + 13'h1;
                  end else begin
                    phase_q <= PH_HI;
                    valid_q <= '0;
                    wr_any_q <= 1'b0;
                  end
                end
                PH_HI: begin
                  addr_q[12:8] <= shift_q[4:0];
                  phase_q <= PH_LO;
                end
                PH_LO: begin
                  addr_q[7:0] <= shift_q;
                  phase_q <= PH_DATA;
                  wp_q <= inhibit_eff; // last fall before first data
                end
                default: begin
                  page_buf[addr_q[PW-1:0]] <= shift_q;
                  valid_q[addr_q[PW-1:0]] <= 1'b1;
                  // roll over inside the page only
                  addr_q[PW-1:0] <= addr_q[PW-1:0] + PW'(1);
                  wr_any_q <= 1'b1;
                end
              endcase
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == 4'h8) begin
              state_q <= ST_TX_ACK;
              oe_q <= 1'b0; // release for the controller's answer
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              oe_q <= ~shift_q[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            ack_q <= ~sda_now;
          end else if (scl_fall) begin
            bit_q <= 4'h0;
            if (ack_q) begin
              // keep sending; address wraps over the whole array
              state_q <= ST_TX;
              shift_q <= mem[addr_q];
              oe_q <= ~mem[addr_q][7];
              addr_q <= addr_q + 13'h1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // internal write cycle
  logic [TWW-1:0] twr_cnt_q; // cycles into the internal write
  logic [`EET_ADDR_BITS-PW-1:0] page_q; // page latched at commit

  // buffer is copied one entry a cycle, long before the cycle ends
  always_ff @(posedge clock) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      twr_cnt_q <= '0;
      page_q <= '0;
    end else if (commit_go) begin
      busy_q <= 1'b1;
      twr_cnt_q <= '0;
      page_q <= addr_q[`EET_ADDR_BITS-1:PW];
    end else if (busy_q) begin
      twr_cnt_q <= twr_cnt_q + TWW'(1);
      if (twr_cnt_q == TWW'(TWR_CYCLES - 1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // array has no reset; a real part keeps its contents
  always_ff @(posedge clock) begin
    if (busy_q && twr_cnt_q < TWW'(`EET_PAGE_BYTES) && valid_q[twr_cnt_q[PW-1:0]]) begin
      mem[{page_q, twr_cnt_q[PW-1:0]}] <= page_buf[twr_cnt_q[PW-1:0]];
    end
  end

  assign sda_out = 1'b0; // only ever pulls low
  assign sda_oe = oe_q;
  assign device_ready = ready_q;
  assign write_busy = busy_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  oe_timing_a: assert property ($changed(oe_q) |-> $past(scl_fall) || $past(start_det) || $past(stop_det)) else $error("sda drive changed off a falling edge");
  not_ready_a: assert property (!ready_q |-> !oe_q) else $error("sda driven before ready");
  start_decode_a: assert property (ready_q && start_det |=> state_q == ST_RX && bit_q == 4'h0 && phase_q == PH_DEV) else $error("start did not restart decode");
  stop_idle_a: assert property (ready_q && stop_det |=> state_q == ST_IDLE && !oe_q) else $error("stop did not end command");
  addr_miss_a: assert property (state_q == ST_RX_ACK && phase_q == PH_DEV && shift_q[7:1] != {DEV_TYPE, strap_eff} |-> !oe_q) else $error("acknowledged foreign address");
  busy_nak_a: assert property (busy_q && state_q == ST_RX_ACK && phase_q == PH_DEV |-> !oe_q) else $error("acknowledged during internal write");
  wp_nak_a: assert property (state_q == ST_RX_ACK && phase_q == PH_DATA && wp_q |-> !oe_q) else $error("data acknowledged while inhibited");
  read_dir_a: assert property (state_q == ST_RX_ACK && phase_q == PH_DEV && ack_q && shift_q[0] && scl_fall && !start_det && !stop_det |=> state_q == ST_TX) else $error("read request not served");
  glitch_flt_a: assert property ($changed(flt_q[0]) |-> $past(sync2_q[0], 1) == flt_q[0] && $past(sync2_q[0], 2) == flt_q[0] && $past(sync2_q[0], 3) == flt_q[0]) else $error("short scl pulse passed");
  commit_busy_a: assert property (commit_go |=> busy_q [*8]) else $error("internal write ended early");

  read_cov_c: cover property (state_q == ST_TX_ACK && scl_fall && ack_q);
  commit_cov_c: cover property (commit_go);
  wp_cov_c: cover property (state_q == ST_RX_ACK && phase_q == PH_DATA && wp_q);
  restart_cov_c: cover property (start_det && state_q == ST_RX && phase_q == PH_LO);
endmodule : eet_target
`default_nettype wire

//--- eet_ctrl_model.sv
// two-wire bus controller model that owns the serial clock
`default_nettype none
module eet_ctrl_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_rel
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // idle bus: both lines released, clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // every change lands on a falling system clock edge
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  // long lead so a target still holding its ack has let go
  task automatic start();
    tick(8);
    sda_rel = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_rel = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(8);
    sda_rel = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_rel = 1'b1;
    tick(8);
  endtask : stop
  // low phase stretched past the target's answer delay
  task automatic clk_bit(input logic b, output logic r);
    tick(4);
    sda_rel = b;
    tick(4);
    scl = 1'b1;
    tick(3);
    r = sda;
    tick(1);
    scl = 1'b0;
  endtask : clk_bit
  // byte msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
    clk_bit(ack_in, ack);
  endtask : xfer
  // 100 ns low pulse on an idle bus, then clock parked low
  task automatic glitch();
    sda_rel = 1'b0;
    tick(2);
    sda_rel = 1'b1;
    tick(8);
    scl = 1'b0;
  endtask : glitch
endmodule : eet_ctrl_model
`default_nettype wire

//--- eet_target_bench.sv
// self-checking bench for the two-wire eeprom target
`default_nettype none
module eet_target_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  localparam logic [3:0] TYPE = 4'h6; // arbitrary device-type code
  localparam logic [6:0] DEV = {TYPE, 3'h5}; // strapped target
  localparam logic [6:0] DEV0 = {TYPE, 3'h0}; // pinless target
  logic clock, resetn, sda, scl, sda_rel, oe, oe2, wi;
  logic ready, ready2, busy, busy2;
  logic [2:0] strap;
  logic so, so2; // open-drain data values of both targets
  int num_errors = 0;
  int tests_run = 0;
  // open-drain line with pull-up
  assign sda = sda_rel & ~oe & ~oe2;
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  eet_ctrl_model ctl (.clock(clock), .sda(sda), .scl(scl), .sda_rel(sda_rel));
  eet_target #(.DEV_TYPE(TYPE), .PU_CYCLES(200), .TWR_CYCLES(400)) DUT (.clock(clock),
    .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe(oe),
    .strap_bit_zero(strap[0]), .strap_bit_one(strap[1]), .strap_bit_two(strap[2]),
    .write_inhibit(wi), .device_ready(ready), .write_busy(busy));
  // pinless variant shares the bus
  eet_target #(.DEV_TYPE(TYPE), .HAS_PINS(1'b0), .PU_CYCLES(200), .TWR_CYCLES(400)) DUT2 (
    .clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(so2), .sda_oe(oe2),
    .strap_bit_zero(strap[0]), .strap_bit_one(strap[1]), .strap_bit_two(strap[2]),
    .write_inhibit(wi), .device_ready(ready2), .write_busy(busy2));
  // ==========
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // bounded wait: 0 ready, 1 busy, 2 pinless busy
  task automatic await(input int w, input logic v);
    int n;
    n = 0;
    while ((w == 0 ? ready : w == 1 ? busy : busy2) !== v && n < 1000) begin
      @(negedge clock);
      n++;
    end
    if (n == 1000) begin
      num_errors++;
      end_of_test();
    end
  endtask : await
  task automatic head(input logic [6:0] dev, input logic rw, output logic ack);
    logic [7:0] q;
    ctl.start();
    ctl.xfer({dev, rw}, 1'b1, q, ack);
  endtask : head
  task automatic put(input logic [7:0] d, output logic ack);
    logic [7:0] q;
    ctl.xfer(d, 1'b1, q, ack);
  endtask : put
  // byte from the target; the last one is not acknowledged
  task automatic get(input logic last, output logic [7:0] q);
    logic a;
    ctl.xfer(8'hFF, last, q, a);
  endtask : get
  // write command with one or two data bytes; returns four ack levels
  task automatic wr(input logic [6:0] dev, input logic [12:0] a, input logic [7:0] d0,
                    input logic [7:0] d1, input logic two, output logic [3:0] ak);
    head(dev, 1'b0, ak[3]);
    put({3'h0, a[12:8]}, ak[2]);
    put(a[7:0], ak[1]);
    put(d0, ak[0]);
    if (two) put(d1, ak[0]);
    ctl.stop();
  endtask : wr
  // pointer load then turn round with a repeated start
  task automatic point(input logic [6:0] dev, input logic [12:0] a, output logic [3:0] ak);
    head(dev, 1'b0, ak[3]);
    put({3'h0, a[12:8]}, ak[2]);
    put(a[7:0], ak[1]);
    head(dev, 1'b1, ak[0]);
  endtask : point
  // ==========
  task automatic s_power();
    logic a;
    check(oe, 1'b0);
    check({so, so2}, 2'h0);
    head(DEV, 1'b0, a);
    check(a, 1'b1);
    ctl.stop();
    check(ready, 1'b0);
    check(ready2, 1'b0);
    await(0, 1'b1);
  endtask : s_power
  task automatic s_glitch();
    logic a;
    ctl.glitch();
    put({DEV, 1'b0}, a);
    check(a, 1'b1);
    ctl.stop();
  endtask : s_glitch
  // every strap setting: match acks, inverse only hits the pinless part
  task automatic s_addr();
    logic a;
    head({4'h9, 3'h5}, 1'b0, a);
    check(a, 1'b1);
    ctl.stop();
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      head({TYPE, 3'(s)}, 1'b0, a);
      check(a, 1'b0);
      ctl.stop();
      head({TYPE, ~3'(s)}, 1'b0, a);
      check(a, 1'(s != 7));
      ctl.stop();
    end
    strap = 3'h5;
  endtask : s_addr
  task automatic s_write();
    logic [3:0] ak;
    logic a;
    wr(DEV, 13'h0000, 8'h5A, 8'h00, 1'b0, ak);
    await(1, 1'b0);
    wi = 1'b1;
    wr(DEV, 13'h0000, 8'h11, 8'h00, 1'b0, ak);
    check(ak, 4'h1);
    check(busy, 1'b0);
    wr(DEV0, 13'h0000, 8'h5A, 8'h00, 1'b0, ak);
    check(ak, 4'h0);
    await(2, 1'b0);
    wi = 1'b0;
    // page wrap: second byte lands at the page start
    wr(DEV, 13'h1FFF, 8'hA5, 8'h3C, 1'b1, ak);
    check(ak, 4'h0);
    check(busy, 1'b1);
    head(DEV, 1'b0, a);
    check(a, 1'b1);
    ctl.stop();
    await(1, 1'b0);
  endtask : s_write
  task automatic s_read();
    logic [3:0] ak;
    logic [7:0] q;
    point(DEV, 13'h1FFF, ak);
    check(ak, 4'h0);
    get(1'b0, q);
    check(q, 8'hA5);
    get(1'b1, q);
    check(q, 8'h5A);
    ctl.stop();
    point(DEV, 13'h1FE0, ak);
    get(1'b1, q);
    check(q, 8'h3C);
    ctl.stop();
  endtask : s_read
  task automatic s_reset();
    resetn = 1'b0;
    repeat (3) @(negedge clock);
    check(ready, 1'b0);
    resetn = 1'b1;
    await(0, 1'b1);
  endtask : s_reset
  // ==========
  initial begin
    resetn = 1'b0;
    wi = 1'b0;
    strap = 3'h5;
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    s_power();
    s_glitch();
    s_addr();
    s_write();
    s_read();
    s_reset();
    end_of_test();
  end
endmodule : eet_target_bench
`default_nettype wire
